// *** sleep_ctrl.sv ***
// sleep mode and power reduction controller with apb registers
//
// Behaviour
// - sleep only when armed and sleep executed
// - interrupt wake adds four hold cycles
// - register file and sram kept intact
// - reset in sleep restarts at reset vector
// - mode 000 idle stops cpu, flash
// - idle wakes on any enabled interrupt
// - mode 010 power-down stops all clocks
// - power-down wakes only on listed events
// - power-down wake delay from clock fuses
// - mode 011 behaves as power-down
// - mode 110 standby keeps oscillator, six cycles
// - mode 111 same as standby
// - gate bit stops and freezes peripheral
// - clearing gate bit resumes same state
// - comparator off in all non-idle modes
// - enabled brown-out detector stays active
// - enabled watchdog keeps running always
// - reference on with bod, or with acbg while comparator not disabled, also in sleep
// - input buffers off when io clock stops
// - debug fuse keeps main clock running
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"
module sleep_ctrl #(
    parameter int DLY_W      = 20,
    parameter int START_TIME = 16384
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // core
    input  wire logic        sleep_exec_i,
    input  wire logic        core_reset_i,
    output logic             core_hold_o,
    output logic             irq_resume_o,
    output logic             reset_vector_o,
    // wake sources
    input  wire logic        irq_any_i,
    input  wire logic [7:0]  ext_irq_lines_i,
    input  wire logic [7:0]  ext_irq_level_i,
    input  wire logic        pin_change_irq_i,
    input  wire logic        usb_wakeup_irq_i,
    input  wire logic        usb_frame_start_irq_i,
    input  wire logic        twi_match_i,
    // clock and analog enables
    output logic             cpu_clk_en_o,
    output logic             flash_clk_en_o,
    output logic             io_clk_en_o,
    output logic             osc_en_o,
    output logic             comp_en_o,
    output logic             vref_en_o,
    output logic             in_buf_en_o,
    output logic             bod_en_o,
    output logic             wdt_en_o,
    output logic [7:0]       gate_a_o,
    output logic [7:0]       gate_b_o
);
    // ************************************************************
    // registers
    // ************************************************************
    logic                    arm_ff;
    logic [2:0]              mode_ff;
    logic [7:0]              gate_a_ff;
    logic [7:0]              gate_b_ff;
    logic [9:0]              cfg_ff;
    logic [2:0]              act_mode_ff;
    sleep_ctrl_pkg::pwr_state_t st_ff;
    sleep_ctrl_pkg::pwr_state_t nxt_st;
    logic [2:0]              hold_ff;
    logic                    resumed_ff;
    logic                    load;
    logic [DLY_W-1:0]        load_cnt;
    logic                    tmr_done;
    logic                    wake;
    logic                    deep;
    logic                    wr;
    logic                    rd;

    initial begin
        if (DLY_W < 8 || (START_TIME << 3) >= (1 << DLY_W) || START_TIME < `STBY_WAKE)
            $error("sleep_ctrl: start time does not fit the delay counter");
    end

    // power-down and power-save share every behaviour
    function automatic logic is_deep(input logic [2:0] m);
        is_deep = (m == `MODE_PDOWN) || (m == `MODE_PSAVE);
    endfunction : is_deep

    function automatic logic is_stby(input logic [2:0] m);
        is_stby = (m == `MODE_STBY) || (m == `MODE_XSTBY);
    endfunction : is_stby

    // ************************************************************
    // apb slave: zero wait states, error on unmapped
    // ************************************************************
    assign wr = psel_i && penable_i && pwrite_i;
    assign rd = psel_i && !penable_i && !pwrite_i;

    // sleep control register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_ff  <= 1'b0;
            mode_ff <= 3'h0;
        end else if (wr && paddr_i == `OFS_SLEEP_CTRL) begin
            arm_ff  <= pwdata_i[`SLP_ARM_BIT];
            mode_ff <= pwdata_i[`SLP_MODE_LSB +: 3];
        end
    end

    // gate bits only exist for the real peripherals
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_a_ff <= `RST_ZERO8;
            gate_b_ff <= `RST_ZERO8;
        end else if (wr && paddr_i == `OFS_GATE_A) begin
            gate_a_ff <= pwdata_i[7:0] & `GATE_A_MASK;
        end else if (wr && paddr_i == `OFS_GATE_B) begin
            gate_b_ff <= pwdata_i[7:0] & `GATE_B_MASK;
        end
    end

    // fuse and analog configuration word
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_ff <= `CFG_RESET;
        end else if (wr && paddr_i == `OFS_CFG) begin
            cfg_ff <= pwdata_i[9:0];
        end
    end

    // read data and answer registered in setup, so pready is a flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            if (rd) begin
                unique case (paddr_i)
                    `OFS_SLEEP_CTRL: prdata_o <= {28'h0, mode_ff, arm_ff};
                    `OFS_GATE_A:     prdata_o <= {24'h0, gate_a_ff};
                    `OFS_GATE_B:     prdata_o <= {24'h0, gate_b_ff};
                    `OFS_CFG:        prdata_o <= {22'h0, cfg_ff};
                    `OFS_STATUS:     prdata_o <= {26'h0, resumed_ff, act_mode_ff, st_ff[1:0]};
                    default: begin
                        prdata_o <= 32'h0000_0000;
                    end
                endcase
            end
            if (psel_i && !penable_i &&
                !(paddr_i inside {`OFS_SLEEP_CTRL, `OFS_GATE_A, `OFS_GATE_B,
                                  `OFS_CFG, `OFS_STATUS}))
                pslverr_o <= 1'b1;
        end
    end

    // ************************************************************
    // sleep state machine
    // ************************************************************
    assign deep = is_deep(act_mode_ff) || is_stby(act_mode_ff);

    // deep modes only hear the asynchronous sources
    always_comb begin
        if (deep) begin
            wake = twi_match_i || |ext_irq_lines_i[3:0]
                 || |(ext_irq_lines_i[7:4] & ext_irq_level_i[7:4])
                 || pin_change_irq_i || usb_wakeup_irq_i;
        end else begin
            wake = irq_any_i || |ext_irq_lines_i || pin_change_irq_i
                 || usb_wakeup_irq_i || usb_frame_start_irq_i || twi_match_i;
        end
    end

    // startup delay: fuse time for deep, six cycles for standby or with the debug fuse
    always_comb begin
        load     = 1'b0;
        load_cnt = DLY_W'(START_TIME);
        if (st_ff == sleep_ctrl_pkg::ST_SLEEP && wake) begin
            load = 1'b1;
            if (is_stby(act_mode_ff) || cfg_ff[`CFG_DBG_BIT])
                load_cnt = DLY_W'(`STBY_WAKE);
            else if (is_deep(act_mode_ff))
                load_cnt = DLY_W'(START_TIME) << cfg_ff[`CFG_CLOCK_SELECT_FUSES_LSB +: 2];
            else
                load_cnt = DLY_W'(1);
        end
    end

    wake_timer #(
        .W       (DLY_W)
    ) u_wake_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (load),
        .count_i (load_cnt),
        .done_o  (tmr_done)
    );

    // next state
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            sleep_ctrl_pkg::ST_RUN:
                if (sleep_exec_i && arm_ff) nxt_st = sleep_ctrl_pkg::ST_SLEEP;
            sleep_ctrl_pkg::ST_SLEEP:
                if (wake) nxt_st = sleep_ctrl_pkg::ST_START;
            sleep_ctrl_pkg::ST_START:
                if (tmr_done) nxt_st = sleep_ctrl_pkg::ST_HOLD;
            sleep_ctrl_pkg::ST_HOLD:
                if (hold_ff == 3'(`WAKE_EXTRA - 1)) nxt_st = sleep_ctrl_pkg::ST_RUN;
            default: nxt_st = sleep_ctrl_pkg::ST_RUN;
        endcase
    end

    // a core reset aborts sleep; ram is never touched here
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= sleep_ctrl_pkg::ST_RUN;
        end else if (core_reset_i) begin
            st_ff <= sleep_ctrl_pkg::ST_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // mode latched at the sleep instruction; later writes ignored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_mode_ff <= `MODE_IDLE;
        end else if (st_ff == sleep_ctrl_pkg::ST_RUN && sleep_exec_i && arm_ff) begin
            act_mode_ff <= mode_ff;
        end
    end

    // four extra halted cycles after start-up
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_ff <= 3'h0;
        end else if (st_ff == sleep_ctrl_pkg::ST_HOLD) begin
            hold_ff <= hold_ff + 3'h1;
        end else begin
            hold_ff <= 3'h0;
        end
    end

    // resume and reset-vector pulses toward the core
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_resume_o   <= 1'b0;
            reset_vector_o <= 1'b0;
            resumed_ff     <= 1'b0;
        end else begin
            irq_resume_o   <= (st_ff == sleep_ctrl_pkg::ST_HOLD)
                              && (nxt_st == sleep_ctrl_pkg::ST_RUN) && !core_reset_i;
            reset_vector_o <= core_reset_i && (st_ff != sleep_ctrl_pkg::ST_RUN);
            if (st_ff == sleep_ctrl_pkg::ST_HOLD)
                resumed_ff <= 1'b1;
            else if (rd && paddr_i == `OFS_STATUS)
                resumed_ff <= 1'b0;
        end
    end

    // ************************************************************
    // clock, analog and buffer enables
    // ************************************************************
    sleep_ctrl_pkg::clk_gates_t g;
    always_comb begin
        logic asleep;
        asleep         = (st_ff == sleep_ctrl_pkg::ST_SLEEP) || (st_ff == sleep_ctrl_pkg::ST_START);
        g.cpu_clk_en   = (st_ff == sleep_ctrl_pkg::ST_RUN);
        g.flash_clk_en = (st_ff == sleep_ctrl_pkg::ST_RUN);
        g.io_clk_en    = !(asleep && deep);
        g.osc_en       = !(asleep && is_deep(act_mode_ff))
                         || cfg_ff[`CFG_DBG_BIT];
        g.comp_en      = !cfg_ff[`CFG_ACD_BIT] && !(asleep && deep);
        g.vref_en      = cfg_ff[`CFG_BOD_BIT]
                         || (!cfg_ff[`CFG_ACD_BIT] && cfg_ff[`CFG_ACBG_BIT]
                             && (g.comp_en || cfg_ff[`CFG_ACBG_BIT]));
        g.in_buf_en    = g.io_clk_en;
    end

    // all enables registered so outputs come from flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_hold_o    <= 1'b0;
            cpu_clk_en_o   <= 1'b1;
            flash_clk_en_o <= 1'b1;
            io_clk_en_o    <= 1'b1;
            osc_en_o       <= 1'b1;
            comp_en_o      <= 1'b1;
            vref_en_o      <= 1'b0;
            in_buf_en_o    <= 1'b1;
            bod_en_o       <= 1'b0;
            wdt_en_o       <= 1'b0;
            gate_a_o       <= `RST_ZERO8;
            gate_b_o       <= `RST_ZERO8;
        end else begin
            core_hold_o    <= (st_ff != sleep_ctrl_pkg::ST_RUN);
            cpu_clk_en_o   <= g.cpu_clk_en;
            flash_clk_en_o <= g.flash_clk_en;
            io_clk_en_o    <= g.io_clk_en;
            osc_en_o       <= g.osc_en;
            comp_en_o      <= g.comp_en;
            vref_en_o      <= g.vref_en;
            in_buf_en_o    <= g.in_buf_en;
            bod_en_o       <= cfg_ff[`CFG_BOD_BIT];
            wdt_en_o       <= cfg_ff[`CFG_WDT_BIT];
            gate_a_o       <= gate_a_ff;
            gate_b_o       <= gate_b_ff;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || core_reset_i);

    AST_ARM_NEEDED: assert property (
        st_ff == sleep_ctrl_pkg::ST_RUN && !arm_ff |=> st_ff == sleep_ctrl_pkg::ST_RUN)
        else $error("sleep entered without arm");
    AST_HOLD_FOUR: assert property (
        st_ff == sleep_ctrl_pkg::ST_START ##1 st_ff == sleep_ctrl_pkg::ST_HOLD
        |-> st_ff == sleep_ctrl_pkg::ST_HOLD [*4] ##1 st_ff == sleep_ctrl_pkg::ST_RUN)
        else $error("hold not four cycles");
    AST_IDLE_CPU_OFF: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP |=> !cpu_clk_en_o && !flash_clk_en_o)
        else $error("cpu clock runs in sleep");
    AST_IDLE_IO_ON: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP && act_mode_ff == `MODE_IDLE |=> io_clk_en_o)
        else $error("io clock stopped in idle");
    AST_PDOWN_OSC: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP && is_deep(act_mode_ff) && !cfg_ff[`CFG_DBG_BIT]
        |=> !osc_en_o)
        else $error("oscillator on in power-down");
    AST_STBY_OSC: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP && is_stby(act_mode_ff) |=> osc_en_o && !io_clk_en_o)
        else $error("standby clocks wrong");
    AST_STBY_SIX: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP && is_stby(act_mode_ff) && wake
        |-> ##[6:8] st_ff == sleep_ctrl_pkg::ST_HOLD)
        else $error("standby wake not six cycles");
    AST_COMP_OFF: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP && deep |=> !comp_en_o)
        else $error("comparator on in deep sleep");
    AST_BUF_OFF: assert property (
        st_ff == sleep_ctrl_pkg::ST_SLEEP && deep |=> !in_buf_en_o && !io_clk_en_o)
        else $error("input buffers on without io clock");
    AST_GATE_FOLLOW: assert property (
        wr && paddr_i == `OFS_GATE_A |=> ##1 gate_a_o == ($past(pwdata_i[7:0], 2) & `GATE_A_MASK))
        else $error("gate bits not applied");

    COV_IDLE: cover property (st_ff == sleep_ctrl_pkg::ST_SLEEP && act_mode_ff == `MODE_IDLE);
    COV_PDOWN: cover property (st_ff == sleep_ctrl_pkg::ST_SLEEP && is_deep(act_mode_ff));
    COV_STBY: cover property (st_ff == sleep_ctrl_pkg::ST_SLEEP && is_stby(act_mode_ff));
    COV_RESUME: cover property (irq_resume_o);
endmodule : sleep_ctrl

// *** sleep_ctrl_defs.svh ***
// constants for the sleep and power controller
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH
// apb byte offsets
`define OFS_SLEEP_CTRL   12'h000
`define OFS_GATE_A       12'h004
`define OFS_GATE_B       12'h008
`define OFS_CFG          12'h00c
`define OFS_STATUS       12'h010
// sleep_control_reg fields
`define SLP_ARM_BIT      0
`define SLP_MODE_LSB     1
// mode encodings
`define MODE_IDLE        3'h0
`define MODE_PDOWN       3'h2
`define MODE_PSAVE       3'h3
`define MODE_STBY        3'h6
`define MODE_XSTBY       3'h7
// config register fields
`define CFG_CLOCK_SELECT_FUSES_LSB    0
`define CFG_XTAL_BIT     4
`define CFG_BOD_BIT      5
`define CFG_DBG_BIT      6
`define CFG_ACD_BIT      7
`define CFG_ACBG_BIT     8
`define CFG_WDT_BIT      9
// gate and config register reset values and writable masks
`define GATE_A_MASK      8'h2c
`define GATE_B_MASK      8'h81
`define RST_ZERO8        8'h00
`define CFG_RESET        10'h000
// timing counts in cycles
`define WAKE_EXTRA       4
`define STBY_WAKE        6
`endif

// *** sleep_ctrl_pkg.sv ***
// types for the sleep and power controller
package sleep_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_SLEEP = 3'b001,
        ST_START = 3'b011,
        ST_HOLD  = 3'b010
    } pwr_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic flash_clk_en;
        logic io_clk_en;
        logic osc_en;
        logic comp_en;
        logic vref_en;
        logic in_buf_en;
    } clk_gates_t;
endpackage : sleep_ctrl_pkg

// *** wake_timer.sv ***
// down counter that times the start-up delay after wake-up
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"
module wake_timer #(
    parameter int W = 20
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              done_o
);
    logic [W-1:0] cnt_ff;

    initial begin
        if (W < 4) $error("wake_timer width too small");
    end

    // counts to zero; done is high while idle at zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (load_i) begin
            cnt_ff <= count_i;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end

    assign done_o = (cnt_ff == '0) && !load_i;
endmodule : wake_timer

// *** core_model.sv ***
// processor core stand-in that executes sleep and notes how it woke
`timescale 1ns/1ps
module core_model (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  go_i,
    input  wire logic  hold_i,
    input  wire logic  resume_i,
    input  wire logic  rvec_i,
    output logic       sleep_exec_o,
    output logic [1:0] woke_o
);
    // ****************************************
    // sleep instruction and wake record
    // ****************************************
    // one sleep pulse per go, never while halted
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_exec_o <= 1'b0;
        end else begin
            sleep_exec_o <= go_i & ~hold_i;
        end
    end
    // sticky cause, cleared by the next sleep so stale wakes never count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            woke_o <= 2'b00;
        end else begin
            woke_o <= go_i ? 2'b00 : (woke_o | {rvec_i, resume_i});
        end
    end
endmodule : core_model

// *** sleep_mode_power_controller_bench.sv ***
// self-checking bench for the sleep and power controller
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"
module sleep_mode_power_controller_bench;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sel   = 1'b0;
    logic        en    = 1'b0;
    logic        wr    = 1'b0;
    logic [11:0] addr  = 12'h000;
    logic [31:0] wdat  = 32'h0;
    logic [6:0]  wk    = 7'h00;
    logic [7:0]  lvl   = 8'h00;
    logic        go    = 1'b0;
    logic        crst  = 1'b0;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic        rdy, err, re, hold, res, rvec, sx;
    logic [8:0]  ck;
    logic [7:0]  ga, gb;
    logic [1:0]  woke;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          lat0, lat;

    // 8 ns period
    always #4 clk_i = ~clk_i;

    // short start-up count keeps deep-sleep wakes brief
    sleep_ctrl #(.START_TIME(8)) u_sleep_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(sel), .penable_i(en),
        .pwrite_i(wr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat),
        .pready_o(rdy), .pslverr_o(err), .sleep_exec_i(sx),
        .core_reset_i(crst), .core_hold_o(hold), .irq_resume_o(res),
        .reset_vector_o(rvec), .irq_any_i(wk[5]),
        .ext_irq_lines_i({3'h0, wk[1], 3'h0, wk[0]}), .ext_irq_level_i(lvl),
        .pin_change_irq_i(wk[2]), .usb_wakeup_irq_i(wk[3]),
        .usb_frame_start_irq_i(wk[6]), .twi_match_i(wk[4]),
        .cpu_clk_en_o(ck[8]), .flash_clk_en_o(ck[7]), .io_clk_en_o(ck[6]),
        .osc_en_o(ck[5]), .comp_en_o(ck[4]), .vref_en_o(ck[3]),
        .in_buf_en_o(ck[2]), .bod_en_o(ck[1]), .wdt_en_o(ck[0]),
        .gate_a_o(ga), .gate_b_o(gb));
    core_model u_core_model (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .hold_i(hold),
        .resume_i(res), .rvec_i(rvec), .sleep_exec_o(sx), .woke_o(woke));

    // ****************************************
    // shared tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        sel <= 1'b1; en <= 1'b0; wr <= w; addr <= a; wdat <= d;
        @(posedge clk_i);
        en <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rq = rdat;
        re = err;
        sel <= 1'b0;
        en <= 1'b0;
    endtask : apb

    // issue sleep, wait a bounded time for the halt to settle
    task doze;
        int n;
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        n = 0;
        while (hold !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        #1;
    endtask : doze

    // sleep in mode m, try a refused source, wake by src, measure release
    task nap(input logic [2:0] m, input logic [9:0] cfg, input logic [8:0] eck,
             input int src, input int bad, output int n);
        apb(1'b1, `OFS_CFG, {22'h0, cfg});
        apb(1'b1, `OFS_SLEEP_CTRL, {28'h0, m, 1'b1});
        doze;
        check(32'(ck), 32'(eck));
        if (bad >= 0) begin
            @(posedge clk_i) wk[bad] <= 1'b1;
            repeat (20) @(posedge clk_i);
            check(32'(hold), 32'h1);
            wk[bad] <= 1'b0;
        end
        @(posedge clk_i) wk[src] <= 1'b1; // level held until released
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hold !== 1'b0 && n < 400);
        wk[src] <= 1'b0;
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h0); // disarm after waking
        check(32'(woke), 32'h1);
    endtask : nap

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            check(rq, 32'h0);
        end
        check(32'(ck), 32'h1f4);
        apb(1'b1, 12'h014, 32'hffff_ffff);
        apb(1'b0, 12'h014, 32'h0);
        check(rq, 32'h0);
        check(32'(re), 32'h1);
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h0e);
        apb(1'b0, `OFS_SLEEP_CTRL, 32'h0);
        check(rq, 32'h0e);
        // no peripheral is active here, so gating is safe
        apb(1'b1, `OFS_GATE_A, 32'hff);
        apb(1'b1, `OFS_GATE_B, 32'hff);
        apb(1'b0, `OFS_GATE_A, 32'h0);
        check(32'({rq[7:0], ga}), 32'h2c2c);
        apb(1'b0, `OFS_GATE_B, 32'h0);
        check(32'({rq[7:0], gb}), 32'h8181);
        apb(1'b1, `OFS_GATE_A, 32'h0);
        apb(1'b1, `OFS_GATE_B, 32'h0);
        // gate outputs lag the write by two flops
        repeat (2) @(posedge clk_i);
        check(32'({ga, gb}), 32'h0000);
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h0);
    endtask : t_regs

    // mode set but not armed: sleep must be ignored
    task t_unarmed;
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h04);
        doze;
        repeat (8) @(posedge clk_i);
        check(32'(hold), 32'h0);
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h0);
    endtask : t_unarmed

    task t_idle;
        nap(`MODE_IDLE, 10'h000, 9'h074, 6, -1, lat0);
        check(32'(lat0 >= 5), 32'h1);
        // status: resumed flag set, idle latched, running; cleared by the read
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rq, 32'h20);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rq, 32'h0);
        nap(`MODE_IDLE, 10'h080, 9'h064, 5, -1, lat);
        check(lat, lat0);
    endtask : t_idle

    // deep modes differ from idle by start-up delay, stopped clocks and refused wake sources
    task t_deep;
        @(posedge clk_i) lvl <= 8'hf0;
        nap(`MODE_PDOWN, 10'h000, 9'h000, 0, 5, lat);
        check(lat, lat0 + 7);
        nap(`MODE_PDOWN, 10'h001, 9'h000, 1, 5, lat);
        check(lat, lat0 + 15);
        nap(`MODE_PSAVE, 10'h320, 9'h00b, 2, 5, lat);
        check(lat, lat0 + 7);
        nap(`MODE_STBY, 10'h010, 9'h020, 3, 5, lat);
        check(lat, lat0 + 5);
        nap(`MODE_XSTBY, 10'h010, 9'h020, 4, 6, lat);
        check(lat, lat0 + 5);
        nap(`MODE_PDOWN, 10'h040, 9'h020, 0, -1, lat);
        check(lat, lat0 + 5);
    endtask : t_deep

    // reset while asleep restarts at the reset vector, not after sleep
    task t_reset;
        apb(1'b1, `OFS_CFG, 32'h0);
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h05);
        doze;
        @(posedge clk_i) crst <= 1'b1;
        @(posedge clk_i) crst <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        check(32'({woke, hold}), 32'h4);
        apb(1'b1, `OFS_SLEEP_CTRL, 32'h0);
    endtask : t_reset

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_unarmed;
        t_idle;
        t_deep;
        t_reset;
        conclude;
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        conclude;
    end
endmodule : sleep_mode_power_controller_bench
